// [audio_serial_pkg.sv]
// constants shared by the serial audio port and its sample fifo
package audio_serial_pkg;

  // register map (word addresses on the plain register port)
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_FORMAT = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [15:0] FORMAT_RESET = 16'h0000;

  // format register field positions
  localparam int POS_FSRC = 13;
  localparam int POS_BSRC = 10;
  localparam int POS_FMODE = 9;
  localparam int POS_FPOL = 8;
  localparam int POS_BPOL = 7;
  localparam int POS_WLEN = 5;
  localparam int POS_MSB = 3;
  localparam int POS_TDM = 0;

  // status register field positions
  localparam int STAT_POS_LOCKED = 0;
  localparam int STAT_POS_UNDERRUN = 1;
  localparam int STAT_POS_LEVEL = 4;
  localparam int STAT_POS_SLOT = 8;

  // field codes
  localparam logic [2:0] SRC_MASTER = 3'h4;
  localparam logic [1:0] WLEN_24 = 2'h0;
  localparam logic [1:0] WLEN_16 = 2'h1;
  localparam logic [1:0] WLEN_32 = 2'h2;
  localparam logic [1:0] WLEN_FLEX = 2'h3;
  localparam logic [1:0] MSB_I2S = 2'h0;
  localparam logic [1:0] MSB_LEFT = 2'h1;
  localparam logic [1:0] MSB_RJ24 = 2'h2;
  localparam logic [1:0] MSB_RJ16 = 2'h3;
  localparam logic [2:0] TDM_2X32 = 3'h0;
  localparam logic [2:0] TDM_4X32 = 3'h1;
  localparam logic [2:0] TDM_8X32 = 3'h2;
  localparam logic [2:0] TDM_16X32 = 3'h3;
  localparam logic [2:0] TDM_4X16 = 3'h4;
  localparam logic [2:0] TDM_2X16 = 3'h5;

  // bit counts selected by the codes
  localparam logic [5:0] WBITS_24 = 6'h18;
  localparam logic [5:0] WBITS_16 = 6'h10;
  localparam logic [5:0] WBITS_32 = 6'h20;
  localparam logic [4:0] DLY_I2S = 5'h01;
  localparam logic [4:0] DLY_LEFT = 5'h00;
  localparam logic [4:0] DLY_RJ24 = 5'h08;
  localparam logic [4:0] DLY_RJ16 = 5'h10;
  localparam logic [8:0] FRAME_LAST_2X32 = 9'h03f;
  localparam logic [8:0] FRAME_LAST_4X16 = 9'h03f;
  localparam logic [8:0] FRAME_LAST_2X16 = 9'h01f;
  localparam logic [4:0] SLOT_LAST_32 = 5'h1f;
  localparam logic [4:0] SLOT_LAST_16 = 5'h0f;

  // sample width and master bit clock timing
  localparam int SAMPLE_W = 32;
  localparam int SYS_PERIOD_NS = 40;
  localparam int BCLK_HALF_NS = 160;
  localparam int BCLK_HALF_CYC = BCLK_HALF_NS / SYS_PERIOD_NS;

  typedef enum logic [0:0] {
    LINK_HUNT = 1'b0,
    LINK_LOCKED = 1'b1
  } link_state_t;

endpackage

// [audio_serial_port.sv]
// serial audio port with frame format control, clock master/slave and sample fifo
//
// Added by the designer: the address-and-strobe port and the placing of the registers.

////////////////////////////////////////////////////////////////////////////////

module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_srst, // synchronous reset
  input wire logic i_valid, // fill side word valid
  output logic o_ready, // fill side room available
  input wire logic [WIDTH-1:0] i_data, // fill side word
  output logic o_valid, // drain side word present
  input wire logic i_ready, // drain side takes word
  output logic [WIDTH-1:0] o_data, // drain side head word
  output logic [$clog2(DEPTH):0] o_level // words held
);
  localparam int AW = $clog2(DEPTH);

  // refuse sizes that the pointer arithmetic cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("sample_fifo: depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t n;
  logic push;
  logic pop;

  assign o_ready = q.cnt != (AW+1)'(DEPTH);
  assign o_valid = q.cnt != '0;
  assign o_data = q.mem[q.rd];
  assign o_level = q.cnt;
  assign push = i_valid && o_ready;
  assign pop = i_ready && o_valid;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wr] = i_data;
      n.wr = q.wr + AW'(1);
    end
    if (pop) begin
      n.rd = q.rd + AW'(1);
    end
    n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule // sample_fifo

////////////////////////////////////////////////////////////////////////////////

module audio_serial_port #(
  parameter int FIFO_DEPTH = 4,
  parameter int BCLK_HALF = audio_serial_pkg::BCLK_HALF_CYC
) (
  input wire logic i_sys_clk, // system clock, 25 MHz
  input wire logic i_srst, // synchronous reset, active high
  input wire logic [3:0] i_addr, // register word address
  input wire logic [15:0] i_wdata, // register write data
  input wire logic i_wr, // register write strobe
  input wire logic i_rd, // register read strobe
  output logic [15:0] o_rdata, // read data, cycle after the strobe
  input wire logic [3:0] i_bclk_pins, // bit clock pin levels, pin 0 is this port's own
  input wire logic [3:0] i_fclk_pins, // frame clock pin levels, pin 0 is this port's own
  output logic o_bclk, // bit clock drive value
  output logic o_bclk_oe, // bit clock pin 0 driven
  output logic o_fclk, // frame clock drive value
  output logic o_fclk_oe, // frame clock pin 0 driven
  input wire logic i_sdata, // serial data in
  output logic o_sdata, // serial data out
  input wire logic [31:0] i_tx_data, // sample to send, msb aligned
  input wire logic i_tx_valid, // sample to send valid
  output logic o_tx_ready, // fifo takes the sample
  output logic [31:0] o_rx_data, // received sample, msb aligned
  output logic o_rx_valid, // received sample pulse
  output logic [3:0] o_rx_channel // slot of the received sample
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // the divider is 8 bits and the level field must stay below the slot field
  if (BCLK_HALF < 1 || BCLK_HALF > 255 || FIFO_DEPTH > 8) begin : g_bad_cfg
    $error("audio_serial_port: bit clock half period or fifo depth out of range");
  end

  typedef struct packed {
    logic [15:0] fmt;
    audio_serial_pkg::link_state_t link;
    logic [2:0] bsync;
    logic [2:0] fsync;
    logic [2:0] dsync;
    logic [7:0] div;
    logic bclk;
    logic fclk;
    logic fprev;
    logic sdata;
    logic [8:0] bitc;
    logic [31:0] txw;
    logic [31:0] rxw;
    logic [31:0] rxd;
    logic rxv;
    logic [3:0] rxch;
    logic underrun;
    logic [15:0] rdata;
  } port_state_t;

  port_state_t q;
  port_state_t n;

  logic fifo_valid;
  logic fifo_pop;
  logic [31:0] fifo_data;
  logic [LW-1:0] fifo_level;

  logic bmaster;
  logic fmaster;
  logic fmode;
  logic fpol;
  logic bpol;
  logic [1:0] wcode;
  logic [1:0] mcode;
  logic [2:0] tcode;
  logic slot32;
  logic [8:0] frame_last;
  logic [4:0] slot_last;
  logic [4:0] dly;
  logic [5:0] wbits;
  logic bsel;
  logic fsel;
  logic m_tick;
  logic rise;
  logic fall;
  logic launch;
  logic sample;

  sample_fifo #(
    .WIDTH(audio_serial_pkg::SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_valid(i_tx_valid),
    .o_ready(o_tx_ready),
    .i_data(i_tx_data),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_data),
    .o_level(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // format decode

  assign bmaster = q.fmt[audio_serial_pkg::POS_BSRC +: 3] == audio_serial_pkg::SRC_MASTER;
  assign fmaster = q.fmt[audio_serial_pkg::POS_FSRC +: 3] == audio_serial_pkg::SRC_MASTER;
  assign fmode = q.fmt[audio_serial_pkg::POS_FMODE];
  assign fpol = q.fmt[audio_serial_pkg::POS_FPOL];
  assign bpol = q.fmt[audio_serial_pkg::POS_BPOL];
  assign wcode = q.fmt[audio_serial_pkg::POS_WLEN +: 2];
  assign mcode = q.fmt[audio_serial_pkg::POS_MSB +: 2];
  assign tcode = q.fmt[audio_serial_pkg::POS_TDM +: 3];

  // slave clocks come from whichever of the four pins the source field names
  assign bsel = i_bclk_pins[q.fmt[audio_serial_pkg::POS_BSRC +: 2]];
  assign fsel = i_fclk_pins[q.fmt[audio_serial_pkg::POS_FSRC +: 2]];

  always_comb begin
    slot32 = 1'b1;
    frame_last = audio_serial_pkg::FRAME_LAST_2X32;
    case (tcode)
      audio_serial_pkg::TDM_2X32, audio_serial_pkg::TDM_4X32,
      audio_serial_pkg::TDM_8X32, audio_serial_pkg::TDM_16X32: begin
        frame_last = 9'((10'(audio_serial_pkg::FRAME_LAST_2X32) + 10'h1) << tcode) - 9'h1;
      end
      audio_serial_pkg::TDM_4X16: begin
        slot32 = 1'b0;
        frame_last = audio_serial_pkg::FRAME_LAST_4X16;
      end
      audio_serial_pkg::TDM_2X16: begin
        slot32 = 1'b0;
        frame_last = audio_serial_pkg::FRAME_LAST_2X16;
      end
      default: begin
        frame_last = audio_serial_pkg::FRAME_LAST_2X32;
      end
    endcase
    slot_last = slot32 ? audio_serial_pkg::SLOT_LAST_32 : audio_serial_pkg::SLOT_LAST_16;
    case (wcode)
      audio_serial_pkg::WLEN_24: wbits = audio_serial_pkg::WBITS_24;
      audio_serial_pkg::WLEN_16: wbits = audio_serial_pkg::WBITS_16;
      audio_serial_pkg::WLEN_32: wbits = audio_serial_pkg::WBITS_32;
      default: wbits = audio_serial_pkg::WBITS_32;
    endcase
    case (mcode)
      audio_serial_pkg::MSB_I2S: dly = audio_serial_pkg::DLY_I2S;
      audio_serial_pkg::MSB_LEFT: dly = audio_serial_pkg::DLY_LEFT;
      audio_serial_pkg::MSB_RJ24: dly = audio_serial_pkg::DLY_RJ24;
      default: dly = audio_serial_pkg::DLY_RJ16;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bit clock edges, from the divider or from the synchronised pin

  assign m_tick = bmaster && q.div == 8'(BCLK_HALF - 1);
  assign rise = bmaster ? (m_tick && !q.bclk) : (q.bsync[1] && !q.bsync[2]);
  assign fall = bmaster ? (m_tick && q.bclk) : (!q.bsync[1] && q.bsync[2]);
  assign launch = bpol ? rise : fall;
  assign sample = bpol ? fall : rise;

  // position within the slot and the slot number for a frame bit count
  function automatic logic [4:0] slot_pos(input logic [8:0] b, input logic s32);
    slot_pos = s32 ? b[4:0] : {1'b0, b[3:0]};
  endfunction

  function automatic logic [3:0] slot_num(input logic [8:0] b, input logic s32);
    slot_num = s32 ? b[8:5] : b[7:4];
  endfunction

  // {inside the word, sample bit index}; bits past the word length are outside
  function automatic logic [5:0] word_bit(input logic [4:0] pos, input logic [4:0] d,
                                          input logic [5:0] wl);
    logic [5:0] k;
    k = {1'b0, pos} - {1'b0, d};
    word_bit = {(pos >= d) && (k < wl), 5'h1f - k[4:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [8:0] bit_n;
    logic [8:0] beff;
    logic [4:0] pos;
    logic [5:0] wb;
    logic [31:0] wsrc;
    logic [31:0] rx;
    logic fs;
    logic fstart;
    logic first;
    logic uset;
    bit_n = '0;
    beff = '0;
    pos = '0;
    wb = '0;
    wsrc = '0;
    rx = '0;
    fs = 1'b0;
    fstart = 1'b0;
    first = 1'b0;
    uset = 1'b0;
    n = q;
    fifo_pop = 1'b0;
    n.rxv = 1'b0;
    n.rdata = '0;
    n.bsync = {q.bsync[1:0], bsel};
    n.fsync = {q.fsync[1:0], fsel};
    n.dsync = {q.dsync[1:0], i_sdata};

    if (bmaster) begin
      n.div = m_tick ? 8'h00 : q.div + 8'h01;
      if (m_tick) begin
        n.bclk = !q.bclk;
      end
    end else begin
      n.div = 8'h00;
      n.bclk = 1'b0;
    end

    // launch edge: advance the frame count, frame clock and outgoing bit
    if (launch) begin
      bit_n = (q.bitc >= frame_last) ? 9'h000 : q.bitc + 9'h001;
      n.bitc = bit_n;
      if (fmaster) begin
        first = fmode ? (bit_n == 9'h000) : (bit_n <= (frame_last >> 1));
        n.fclk = fpol ? first : !first;
        n.link = audio_serial_pkg::LINK_LOCKED;
      end
      pos = slot_pos(bit_n, slot32);
      wsrc = q.txw;
      if (pos == 5'h00 && q.link == audio_serial_pkg::LINK_LOCKED) begin
        wsrc = fifo_valid ? fifo_data : 32'h0000_0000;
        fifo_pop = fifo_valid;
        uset = !fifo_valid;
        n.txw = wsrc;
      end
      wb = word_bit(pos, dly, wbits);
      n.sdata = (q.link == audio_serial_pkg::LINK_LOCKED) && wb[5] && wsrc[wb[4:0]];
    end

    // sample edge: find frame starts and take the incoming bit
    if (sample) begin
      fs = q.fsync[2];
      fstart = (fs != q.fprev) && (fs == fpol);
      n.fprev = fs;
      beff = q.bitc;
      if (!fmaster && fstart) begin
        beff = 9'h000;
        n.bitc = 9'h000;
        n.link = audio_serial_pkg::LINK_LOCKED;
      end
      if (n.link == audio_serial_pkg::LINK_LOCKED) begin
        pos = slot_pos(beff, slot32);
        wb = word_bit(pos, dly, wbits);
        rx = (pos == 5'h00) ? 32'h0000_0000 : q.rxw;
        if (wb[5]) begin
          rx[wb[4:0]] = q.dsync[2];
        end
        n.rxw = rx;
        if (pos == slot_last) begin
          n.rxd = rx;
          n.rxv = 1'b1;
          n.rxch = slot_num(beff, slot32);
        end
      end
    end

    // a status read clears the underrun flag unless it is set again now
    n.underrun = q.underrun || uset;
    if (i_rd) begin
      case (i_addr)
        audio_serial_pkg::ADDR_FORMAT: begin
          n.rdata = q.fmt;
        end
        audio_serial_pkg::ADDR_STATUS: begin
          n.rdata[audio_serial_pkg::STAT_POS_LOCKED] = q.link == audio_serial_pkg::LINK_LOCKED;
          n.rdata[audio_serial_pkg::STAT_POS_UNDERRUN] = q.underrun;
          n.rdata[audio_serial_pkg::STAT_POS_LEVEL +: LW] = fifo_level;
          n.rdata[audio_serial_pkg::STAT_POS_SLOT +: 4] = slot_num(q.bitc, slot32);
          n.underrun = uset;
        end
        default: begin
          n.rdata = '0;
        end
      endcase
    end

    // a new format restarts the link
    if (i_wr && i_addr == audio_serial_pkg::ADDR_FORMAT) begin
      n.fmt = i_wdata;
      n.link = audio_serial_pkg::LINK_HUNT;
      n.bitc = 9'h000;
      n.div = 8'h00;
      n.bclk = 1'b0;
      n.fclk = 1'b0;
      n.sdata = 1'b0;
      // bits gathered under the old word length must not leak into the next slot
      n.rxw = 32'h0000_0000;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      q <= '0;
      q.fmt <= audio_serial_pkg::FORMAT_RESET;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_rdata = q.rdata;
  assign o_bclk = q.bclk;
  assign o_bclk_oe = bmaster;
  assign o_fclk = q.fclk;
  assign o_fclk_oe = fmaster;
  assign o_sdata = q.sdata;
  assign o_rx_data = q.rxd;
  assign o_rx_valid = q.rxv;
  assign o_rx_channel = q.rxch;
endmodule // audio_serial_port

// [audio_serial_port_props.sv]
// concurrent checks on the serial audio port pins
module port_checker #(
  parameter int BCLK_HALF = 4
) (
  input wire logic i_sys_clk, // clock
  input wire logic i_srst, // reset
  input wire logic [3:0] i_addr, // address
  input wire logic [15:0] i_wdata, // write data
  input wire logic i_wr, // write
  input wire logic i_rd, // read
  input wire logic [15:0] o_rdata, // read data
  input wire logic o_bclk, // bit clock
  input wire logic o_bclk_oe, // bit clock driven
  input wire logic o_fclk, // frame clock
  input wire logic o_fclk_oe, // frame clock driven
  input wire logic o_sdata, // data out
  input wire logic o_tx_ready, // fifo room
  input wire logic [31:0] o_rx_data, // rx word
  input wire logic o_rx_valid, // rx pulse
  input wire logic [3:0] o_rx_channel // rx slot
);
  logic [15:0] fmt_q;
  logic [1:0] seen_q;
  logic bclk_q, bm, fm;
  logic [31:0] lowm;
  int gap_q, nch;
  assign bm = fmt_q[12:10] == audio_serial_pkg::SRC_MASTER;
  assign fm = fmt_q[15:13] == audio_serial_pkg::SRC_MASTER;
  assign lowm = fmt_q[6:5] == audio_serial_pkg::WLEN_16 ? 32'h0000ffff :
    fmt_q[6:5] == audio_serial_pkg::WLEN_24 ? 32'h000000ff : 32'h0;
  assign nch = fmt_q[2:0] == audio_serial_pkg::TDM_4X16 ? 4 : fmt_q[2] ? 2 : 2 << fmt_q[1:0];
  // the first three clock changes after any write are not checked, as they may be shortened
  always_ff @(posedge i_sys_clk) begin
    bclk_q <= o_bclk;
    if (i_srst) begin
      fmt_q <= audio_serial_pkg::FORMAT_RESET;
    end else if (i_wr && i_addr == audio_serial_pkg::ADDR_FORMAT) begin
      fmt_q <= i_wdata;
    end
    if (i_srst || i_wr) begin
      gap_q <= 0;
      seen_q <= 2'h0;
    end else if (o_bclk != bclk_q) begin
      gap_q <= 0;
      seen_q <= seen_q == 2'h3 ? 2'h3 : seen_q + 2'h1;
    end else begin
      gap_q <= gap_q + 1;
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);
  sequence fmt_rd_s;
    i_rd && i_addr == audio_serial_pkg::ADDR_FORMAT;
  endsequence
  sequence launch_s;
    $changed(o_bclk) && o_bclk == fmt_q[7];
  endsequence
  fmt_read_a: assert property (fmt_rd_s |=> o_rdata == fmt_q)
    else $error("format read back wrong");
  unmapped_rd_a: assert property (i_rd && i_addr > 4'h1 |=> o_rdata == 16'h0)
    else $error("unmapped read not zero");
  bclk_oe_a: assert property (o_bclk_oe == bm)
    else $error("bit clock enable wrong");
  fclk_oe_a: assert property (o_fclk_oe == fm)
    else $error("frame clock enable wrong");
  bclk_half_a: assert property (bm && seen_q == 2'h3 && o_bclk != bclk_q |-> gap_q == BCLK_HALF - 1)
    else $error("bit clock half period wrong");
  data_edge_a: assert property (bm && $changed(o_sdata) && !$past(i_wr) |-> launch_s)
    else $error("data changed off the launch edge");
  fclk_edge_a: assert property (bm && fm && $changed(o_fclk) && !$past(i_wr) |-> launch_s)
    else $error("frame clock changed off the launch edge");
  rx_pulse_a: assert property (o_rx_valid |=> !o_rx_valid)
    else $error("rx pulse too long");
  rx_zero_a: assert property (o_rx_valid && !$past(i_wr) |-> (o_rx_data & lowm) == 32'h0)
    else $error("rx bits beyond word length");
  rx_chan_a: assert property (o_rx_valid && !$past(i_wr) |-> o_rx_channel < nch)
    else $error("rx slot out of range");
  reset_idle_a: assert property ($fell(i_srst) |-> o_tx_ready && !o_bclk_oe && !o_fclk_oe)
    else $error("state after reset wrong");
endmodule // port_checker

bind audio_serial_port port_checker #(.BCLK_HALF(BCLK_HALF)) port_checker_i (
  .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_bclk(o_bclk), .o_bclk_oe(o_bclk_oe),
  .o_fclk(o_fclk), .o_fclk_oe(o_fclk_oe), .o_sdata(o_sdata), .o_tx_ready(o_tx_ready),
  .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .o_rx_channel(o_rx_channel)
);

// [audio_codec_model.sv]
// converter model: echoes data one bit late, measures frames, can make the clocks
module audio_codec_model (
  input wire logic i_bclk, // port bit clock
  input wire logic i_fclk, // port frame clock
  input wire logic i_sdata, // port data out
  input wire logic i_gen, // model makes the clocks
  input wire logic i_bpol, // launch on rising edge
  input wire logic i_fpol, // frame starts rising
  input wire logic [5:0] i_slot_len, // bits per slot
  output logic o_bclk, // made bit clock
  output logic o_fclk, // made frame clock
  output logic o_sdata, // data into the port
  output logic [31:0] o_word, // last 32 bits at slot end
  output int o_flen, // bits in last frame
  output int o_hi // high bits in last frame
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bclk, fclk, fprev, last;
  logic [31:0] sh;
  int cnt, hi, gcnt;
  assign bclk = i_gen ? o_bclk : i_bclk;
  assign fclk = i_gen ? o_fclk : i_fclk;
  initial begin
    {o_bclk, o_fclk, o_sdata, fprev, last, sh, o_word} = '0;
    {cnt, hi, gcnt, o_flen, o_hi} = '0;
    // 2x32 square frames, falling polarities; clock still when not enabled
    forever begin
      #160;
      o_bclk = i_gen & ~o_bclk;
      if (i_gen && !o_bclk) begin
        gcnt = (gcnt + 1) % 64;
        o_fclk = gcnt >= 32;
      end
    end
  end
  always @(bclk) begin
    if (bclk !== i_bpol) begin
      if (fclk == i_fpol && fclk != fprev) begin
        o_flen = cnt + 1;
        o_hi = hi;
        cnt = 0;
        hi = 0;
      end else begin
        cnt = cnt + 1;
      end
      hi = hi + fclk;
      fprev = fclk;
      sh = {sh[30:0], i_sdata};
      last = i_sdata;
      if (cnt % i_slot_len == i_slot_len - 1) o_word = sh;
    end else begin
      o_sdata = last;
    end
  end
endmodule // audio_codec_model

// [tb.sv]
// bench for the serial audio port: registers, fifo, formats, slave clocking
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] smp = 32'hc3a596f1;
  logic i_sys_clk, i_srst, i_wr, i_rd, i_tx_valid, gen, bpol, fpol, pb, pf, sd;
  logic o_bclk, o_bclk_oe, o_fclk, o_fclk_oe, o_sdata, o_tx_ready, o_rx_valid;
  logic [3:0] i_addr, o_rx_channel;
  logic [15:0] i_wdata, o_rdata, st;
  logic [31:0] o_rx_data, word;
  logic [5:0] slen;
  int flen, hi, n_mismatch, compares;
  audio_serial_port audio_serial_port_i (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_bclk_pins({~pb, ~pb, pb, o_bclk_oe & o_bclk}),
    .i_fclk_pins({~pf, ~pf, pf, o_fclk_oe & o_fclk}),
    .o_bclk(o_bclk), .o_bclk_oe(o_bclk_oe), .o_fclk(o_fclk), .o_fclk_oe(o_fclk_oe),
    .i_sdata(sd), .o_sdata(o_sdata), .i_tx_data(smp), .i_tx_valid(i_tx_valid),
    .o_tx_ready(o_tx_ready), .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid),
    .o_rx_channel(o_rx_channel)
  );
  audio_codec_model audio_codec_model_i (
    .i_bclk(o_bclk), .i_fclk(o_fclk), .i_sdata(o_sdata), .i_gen(gen), .i_bpol(bpol),
    .i_fpol(fpol), .i_slot_len(slen), .o_bclk(pb), .o_fclk(pf), .o_sdata(sd),
    .o_word(word), .o_flen(flen), .o_hi(hi)
  );
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic wait_rx(input int n);
    int t;
    t = 0;
    while (n > 0) begin
      @(posedge i_sys_clk);
      #1;
      if (o_rx_valid === 1'b1) n--;
      t++;
      if (t > 20000) begin
        n_mismatch++;
        $display("[ERR] %0t no received sample", $time);
        summarize();
      end
    end
  endtask
  // bit sent at slot position p for a given delay and word length
  function automatic logic txb(input logic [31:0] s, input int p, d, wl);
    return (p >= d && p - d < wl) ? s[31 - (p - d)] : 1'b0;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_fifo;
    int n;
    logic [15:0] v;
    n = 0;
    i_tx_valid <= 1'b1;
    repeat (6) begin
      @(posedge i_sys_clk);
      if (o_tx_ready === 1'b1) n++;
    end
    i_tx_valid <= 1'b0;
    check(n, 4);
    rd(audio_serial_pkg::ADDR_STATUS, v);
    check(v[6:4], 3'h4);
    check(o_tx_ready, 1'b0);
    $display("fifo fill done");
  endtask
  task automatic t_regs;
    logic [15:0] v;
    rd(audio_serial_pkg::ADDR_FORMAT, v);
    check(v, audio_serial_pkg::FORMAT_RESET);
    wr(audio_serial_pkg::ADDR_FORMAT, 16'h2cf5);
    rd(4'h7, v);
    check(v, 16'h0);
    wr(4'h7, 16'hffff);
    rd(audio_serial_pkg::ADDR_FORMAT, v);
    check(v, 16'h2cf5);
    $display("registers done");
  endtask
  task automatic run_fmt(input logic [15:0] f, input int d, wl, sl, nch);
    logic [31:0] tw, rw;
    logic [3:0] ch;
    rw = '0;
    for (int p = 0; p < 32; p++) begin
      tw[31 - p] = txb(smp, p % sl, d, wl);
      if (p < wl && p + d < sl) rw[31 - p] = txb(smp, (p + d + sl - 1) % sl, d, wl);
    end
    slen <= 6'(sl);
    bpol <= f[7];
    fpol <= f[8];
    wr(audio_serial_pkg::ADDR_FORMAT, f);
    wait_rx(2 * nch + 1);
    ch = o_rx_channel;
    check(o_rx_data, rw);
    wait_rx(1);
    check(o_rx_channel, (ch + 1) % nch);
    check(word, tw);
    check(flen, nch * sl);
    check(hi, f[9] ? (f[8] ? 1 : nch * sl - 1) : nch * sl / 2);
    $display("format %h checked", f);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_srst, i_wr, i_rd, i_tx_valid, gen, bpol, fpol} = 7'h40;
    i_addr = 4'h0;
    i_wdata = 16'h0;
    slen = 6'h20;
    n_mismatch = 0;
    compares = 0;
    repeat (20) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    t_fifo();
    t_regs();
    @(posedge i_sys_clk);
    i_tx_valid <= 1'b1;
    run_fmt(16'h9000, 1, 24, 32, 2);
    run_fmt(16'h93ac, 0, 16, 16, 4);
    run_fmt(16'h9051, 8, 32, 32, 4);
    run_fmt(16'h923a, 16, 16, 32, 8);
    run_fmt(16'h906d, 0, 32, 16, 2);
    run_fmt(16'h9003, 1, 24, 32, 16);
    gen <= 1'b1;
    run_fmt(16'h2400, 1, 24, 32, 2);
    // starve the fifo: slots go out as zeros and the underrun flag sticks
    @(posedge i_sys_clk);
    i_tx_valid <= 1'b0;
    wait_rx(8);
    check(word, 32'h0);
    rd(audio_serial_pkg::ADDR_STATUS, st);
    check(st[1:0], 2'h3);
    check(st[6:4], 3'h0);
    $display("underrun done");
    summarize();
  end
endmodule // tb
